// ### dmem_pkg.sv
/*
  constants for the banked data-memory decoder: core register offsets,
  status field positions, map boundaries and reset values.
  assumes nothing beyond a systemverilog compiler.
*/
package dmem_pkg;
  localparam logic [6:0] OFS_INDIRECT_PORT = 7'h00;
  localparam logic [6:0] OFS_STATUS = 7'h03;
  localparam logic [6:0] OFS_POINTER = 7'h04;
  localparam int STATUS_IRP_BIT = 7;
  localparam int BANK_HI_BIT = 6;
  localparam int BANK_LO_BIT = 5;
  localparam logic [6:0] OFS_GPR_LOW = 7'h20;
  localparam logic [6:0] OFS_SHARED_LOW = 7'h40;
  localparam logic [6:0] OFS_B1_GPR_HIGH = 7'h3f;
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam int GPR_WORDS = 128;
  localparam int GPR_AW = 7;
  typedef enum logic [2:0] {
    REGION_SFR = 3'b001,
    REGION_GPR = 3'b010,
    REGION_NONE = 3'b100
  } region_e;
endpackage : dmem_pkg

// ### gpr_ram.sv
/*
  general purpose static ram: one write port, one read port with registered data.
  assumes a single clock; contents are not reset.
*/
`timescale 1ns/10ps
`default_nettype none
module gpr_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : gpr_ram
`default_nettype wire

// ### banked_data_memory_decoder.sv
/*
  banked data-memory decoder with the core special registers and general ram.
  assumes the core drives one access per strobe; peripheral registers live
  outside and are reached through the ext_ ports.
*/
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module banked_data_memory_decoder
  import dmem_pkg::*;
#(
  parameter int DW = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [6:0] addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DW-1:0] rd_data,
  output logic [1:0] bank_sel,
  output logic [DW-1:0] status_out,
  output logic [DW-1:0] pointer_out,
  output logic ext_wr,
  output logic ext_rd,
  output logic [8:0] ext_addr,
  output logic [DW-1:0] ext_wr_data,
  input wire logic [DW-1:0] ext_rd_data,
  input wire logic ext_hit
);
  logic [DW-1:0] status_ff, nxt_status;
  logic [DW-1:0] pointer_ff, nxt_pointer;
  logic [DW-1:0] rdata_ff, nxt_rdata;
  logic [1:0] rsrc_ff, nxt_rsrc;
  logic [8:0] full_addr;
  logic [1:0] bank;
  logic [6:0] ofs;
  region_e region;
  logic [6:0] ram_addr;
  logic [DW-1:0] ram_q;
  logic ram_we;

  // maps a bank/offset to the ram word or no storage
  function automatic logic [7:0] gpr_map(input logic [1:0] b, input logic [6:0] o);
    logic [7:0] r;
    r = 8'h00;
    if (o >= OFS_SHARED_LOW) begin
      r = {1'b1, o};
    end else if (o >= OFS_GPR_LOW) begin
      case (b)
        2'd0, 2'd2: r = {1'b1, o};
        2'd1, 2'd3: r = {1'b1, 7'h00 | (o - OFS_GPR_LOW)};
        default: r = 8'h00;
      endcase
    end
    return r;
  endfunction : gpr_map

  // indirect access takes pointer plus irp, otherwise bank bits plus offset
  always_comb begin
    if (addr == OFS_INDIRECT_PORT) begin
      full_addr = {status_ff[STATUS_IRP_BIT], pointer_ff};
    end else begin
      full_addr = {status_ff[BANK_HI_BIT], status_ff[BANK_LO_BIT], addr};
    end
  end

  assign bank = full_addr[8:7];
  assign ofs = full_addr[6:0];

  logic [7:0] map_res;
  assign map_res = gpr_map(bank, ofs);
  assign ram_addr = map_res[6:0];

  always_comb begin
    if (ofs < OFS_GPR_LOW) begin
      region = REGION_SFR;
    end else if (map_res[7]) begin
      region = REGION_GPR;
    end else begin
      region = REGION_NONE;
    end
  end

  // indirect through the port itself finds no register
  logic self_ind;
  assign self_ind = (addr == OFS_INDIRECT_PORT) && (ofs == OFS_INDIRECT_PORT);

  logic core_hit;
  assign core_hit = (region == REGION_SFR) && !self_ind &&
                    ((ofs == OFS_STATUS) || (ofs == OFS_POINTER));

  assign ram_we = wr_en && (region == REGION_GPR);
  assign ext_wr = wr_en && (region == REGION_SFR) && !core_hit && !self_ind;
  assign ext_rd = rd_en && (region == REGION_SFR) && !core_hit && !self_ind;
  assign ext_addr = full_addr;
  assign ext_wr_data = wr_data;

  gpr_ram #(
    .WIDTH(DW),
    .DEPTH(GPR_WORDS),
    .AW(GPR_AW)
  ) u_ram (
    .clk_sys(clk_sys),
    .wr_en(ram_we),
    .wr_addr(ram_addr),
    .wr_data(wr_data),
    .rd_addr(ram_addr),
    .rd_data(ram_q)
  );

  // core registers answer at the same offset in every bank
  always_comb begin
    nxt_status = status_ff;
    nxt_pointer = pointer_ff;
    if (wr_en && core_hit && ofs == OFS_STATUS) begin
      nxt_status = wr_data;
    end
    if (wr_en && core_hit && ofs == OFS_POINTER) begin
      nxt_pointer = wr_data;
    end
  end

  // read source: 0 zero, 1 core/ext captured, 2 ram
  always_comb begin
    nxt_rsrc = 2'd0;
    nxt_rdata = '0;
    if (rd_en) begin
      if (region == REGION_GPR) begin
        nxt_rsrc = 2'd2;
      end else if (core_hit) begin
        nxt_rsrc = 2'd1;
        nxt_rdata = (ofs == OFS_STATUS) ? status_ff : pointer_ff;
      end else if (region == REGION_SFR && !self_ind && ext_hit) begin
        nxt_rsrc = 2'd1;
        nxt_rdata = ext_rd_data;
      end else begin
        nxt_rsrc = 2'd0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_ff <= RST_STATUS;
      pointer_ff <= RST_POINTER;
      rdata_ff <= '0;
      rsrc_ff <= 2'd0;
    end else begin
      status_ff <= nxt_status;
      pointer_ff <= nxt_pointer;
      rdata_ff <= nxt_rdata;
      rsrc_ff <= nxt_rsrc;
    end
  end

  always_comb begin
    case (rsrc_ff)
      2'd1: rd_data = rdata_ff;
      2'd2: rd_data = ram_q;
      default: rd_data = '0;
    endcase
  end

  assign bank_sel = {status_ff[BANK_HI_BIT], status_ff[BANK_LO_BIT]};
  assign status_out = status_ff;
  assign pointer_out = pointer_ff;
endmodule : banked_data_memory_decoder
`default_nettype wire

// ### dmem_chk.sv
/* port checker for the banked decoder, bound below.
   assumes one clock and the constants of dmem_pkg */
`timescale 1ns/10ps
`default_nettype none
module dmem_chk import dmem_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [6:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic [1:0] bank_sel,
  input wire logic [7:0] status_out,
  input wire logic [7:0] pointer_out,
  input wire logic ext_wr,
  input wire logic ext_rd,
  input wire logic [8:0] ext_addr,
  input wire logic [7:0] ext_rd_data,
  input wire logic ext_hit
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_ptr_wr; wr_en && addr == OFS_POINTER; endsequence
  a_bank_from_status: assert property (bank_sel == status_out[6:5])
    else $error("bank select differs from status");
  a_status_mirror: assert property (wr_en && addr == OFS_STATUS |=> status_out == $past(wr_data))
    else $error("status write lost");
  a_pointer_write: assert property (s_ptr_wr |=> pointer_out == $past(wr_data))
    else $error("pointer write lost");
  a_idle_zero: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data not zero when idle");
  a_low_to_ext: assert property (wr_en && addr < OFS_GPR_LOW && addr > OFS_POINTER |-> ext_wr && ext_addr == {bank_sel, addr})
    else $error("low offset not routed out");
  a_ram_not_ext: assert property ((wr_en || rd_en) && addr >= OFS_GPR_LOW |-> !ext_wr && !ext_rd)
    else $error("ram offset routed out");
  a_ext_miss: assert property (rd_en && ext_rd && !ext_hit |=> rd_data == 8'h00)
    else $error("missing register read not zero");
  a_ext_data: assert property (rd_en && ext_rd && ext_hit |=> rd_data == $past(ext_rd_data))
    else $error("outside read data wrong");
  a_indirect_addr: assert property (rd_en && ext_rd && addr == OFS_INDIRECT_PORT |-> ext_addr == {status_out[7], pointer_out})
    else $error("indirect address wrong");
endmodule : dmem_chk
bind banked_data_memory_decoder dmem_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .bank_sel(bank_sel),
  .status_out(status_out), .pointer_out(pointer_out), .ext_wr(ext_wr), .ext_rd(ext_rd),
  .ext_addr(ext_addr), .ext_rd_data(ext_rd_data), .ext_hit(ext_hit));
`default_nettype wire

// ### ext_sfr_model.sv
/* one outside special register at offset 0bh in every bank.
   assumes the decoder drives ext_ ports combinationally */
`timescale 1ns/10ps
`default_nettype none
module ext_sfr_model (
  input wire logic clk_sys,
  input wire logic ext_wr,
  input wire logic [8:0] ext_addr,
  input wire logic [7:0] ext_wr_data,
  output logic [7:0] ext_rd_data,
  output logic ext_hit
);
  logic [7:0] val_ff = 8'h00;
  assign ext_hit = ext_addr[6:0] == 7'h0b;
  assign ext_rd_data = ext_hit ? val_ff : ~val_ff;
  always @(posedge clk_sys) if (ext_wr && ext_hit) val_ff <= ext_wr_data;
endmodule : ext_sfr_model
`default_nettype wire

// ### banked_data_memory_decoder_test.sv
/* self-checking bench for the banked decoder.
   assumes ext_sfr_model at the outside ports */
`timescale 1ns/10ps
`default_nettype none
module banked_data_memory_decoder_test import dmem_pkg::*;;
  logic clk_sys = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, ext_wr, ext_rd, ext_hit;
  logic [6:0] addr = 7'h00;
  logic [7:0] wr_data = 8'h00, rd_data, status_out, pointer_out, ext_wr_data, ext_rd_data, d;
  logic [1:0] bank_sel;
  logic [8:0] ext_addr;
  int n_mismatch = 0, total_checks = 0;
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", nm, e, s); end end
  always #5 clk_sys = ~clk_sys;
  banked_data_memory_decoder dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .bank_sel(bank_sel),
    .status_out(status_out), .pointer_out(pointer_out), .ext_wr(ext_wr), .ext_rd(ext_rd),
    .ext_addr(ext_addr), .ext_wr_data(ext_wr_data), .ext_rd_data(ext_rd_data), .ext_hit(ext_hit));
  ext_sfr_model far_u (.clk_sys(clk_sys), .ext_wr(ext_wr), .ext_addr(ext_addr),
    .ext_wr_data(ext_wr_data), .ext_rd_data(ext_rd_data), .ext_hit(ext_hit));
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  task automatic t_map();
    for (int b = 0; b < 4; b++) begin
      wr(OFS_STATUS, {1'b0, 2'(b), 5'h00});
      #1 `CHK("bank_sel", 2'(b), bank_sel)
      wr(7'h20, 8'h10 + 8'(b));
      wr(7'h7f, 8'ha0 + 8'(b));
    end
    for (int b = 0; b < 4; b++) begin
      wr(OFS_STATUS, {1'b0, 2'(b), 5'h00});
      rd(7'h20);
      `CHK("ram 20h", (b % 2) ? 8'h13 : 8'h12, d)
      rd(7'h7f);
      `CHK("ram 7fh", 8'ha3, d)
    end
  endtask : t_map
  task automatic t_ptr();
    wr(OFS_POINTER, 8'ha0);
    rd(OFS_INDIRECT_PORT);
    `CHK("indirect a0h", 8'h13, d)
    wr(OFS_POINTER, 8'h8b);
    wr(OFS_INDIRECT_PORT, 8'h5c);
    rd(OFS_INDIRECT_PORT);
    `CHK("indirect 8bh", 8'h5c, d)
    rd(7'h0c);
    `CHK("unimplemented", 8'h00, d)
  endtask : t_ptr
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 `CHK("status reset", RST_STATUS, status_out)
    `CHK("pointer reset", RST_POINTER, pointer_out)
    t_map();
    t_ptr();
    give_verdict();
  end
  initial begin
    #20000;
    n_mismatch++;
    give_verdict();
  end
endmodule : banked_data_memory_decoder_test
`default_nettype wire
